/* File: hdl/gtm_timer.sv */
// general timer module top: three timer blocks behind an apb slave
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module gtm_timer
  import gtm_pkg::*;
#(
  parameter int NBLK = GTM_NUM_BLOCKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2*NBLK-1:0] ccp_pin_in,
  output logic [2*NBLK-1:0] ccp_pin_out,
  output logic [2*NBLK-1:0] ccp_pin_oe,
  output logic adc_trigger
);
  localparam int H = GTM_HALF_W;

  initial begin
    if (NBLK < 1 || NBLK > 8) $error("gtm_timer: NBLK out of range");
  end

  logic [1:0] cfg_r [NBLK];
  logic [31:0] ctl_r [2*NBLK];
  logic [31:0] load_r [2*NBLK];
  logic [31:0] match_r [2*NBLK];
  logic [1:0] cfg_nxt [NBLK];
  logic [31:0] ctl_nxt [2*NBLK];
  logic [31:0] load_nxt [2*NBLK];
  logic [31:0] match_nxt [2*NBLK];
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;
  logic [2*NBLK-1:0] pin_d1_r;
  logic [2*NBLK-1:0] pin_d2_r;
  logic [2*NBLK-1:0] pin_d3_r;
  logic [2*NBLK-1:0] pin_edge;
  logic [2*NBLK-1:0] tmo;
  logic [2*NBLK-1:0] tmo_sticky_r;
  logic [2*NBLK-1:0] tmo_sticky_nxt;
  logic [2*NBLK-1:0] pwm_raw;
  logic [2*NBLK-1:0] done;
  logic [H-1:0] cnt [2*NBLK];
  logic [H-1:0] capt [2*NBLK];
  logic [2*NBLK-1:0] ccp_out_nxt;
  logic [2*NBLK-1:0] ccp_oe_nxt;
  logic adc_trigger_nxt;
  logic wr_acc;
  logic rd_setup;

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // pins are two-flop synchronised; edges read stage two and three only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d1_r <= '0;
      pin_d2_r <= '0;
      pin_d3_r <= '0;
    end else begin
      pin_d1_r <= ccp_pin_in;
      pin_d2_r <= pin_d1_r;
      pin_d3_r <= pin_d2_r;
    end
  end
  assign pin_edge = pin_d2_r & ~pin_d3_r;

  // in joined mode the low half's time-out clocks the high half
  for (genvar i = 0; i < 2*NBLK; i++) begin : g_half
    localparam int LO = i - (i % 2);
    localparam bit HI = (i % 2 == 1);
    logic joined;
    logic [2:0] md;
    logic tick;
    logic en;
    logic [H-1:0] ld;
    assign joined = (cfg_r[i/2] == GTM_CFG_JOIN);
    assign md = (HI && joined) ? ctl_r[LO][GTM_CTL_MODE_LO+:3]
                               : ctl_r[i][GTM_CTL_MODE_LO+:3];
    assign en = (HI && joined) ? ctl_r[LO][GTM_CTL_EN] : ctl_r[i][GTM_CTL_EN];
    // joined: high half steps on low half wrap, low half ignores one-shot stop
    assign tick = (HI && joined) ? tmo[LO] : 1'b1;
    // joined low half wraps through all ones until the high half is spent
    assign ld = !joined ? load_r[i][H-1:0]
              : HI ? load_r[LO][31:16]
              : (cnt[LO + 1] == '0 || !en) ? load_r[i][H-1:0]
              : {H{1'b1}};
    gtm_counter #(
      .W(H),
      .PW(GTM_PRE_W)
    ) u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .enable(en),
      .mode((joined && i % 2 == 0 && md == GTM_M_ONESHOT) ? GTM_M_PERIODIC : md),
      .evt_mode(joined ? 1'b0 : ctl_r[i][GTM_CTL_EVT]),
      .pre_load(joined ? '0 : ctl_r[i][GTM_CTL_PRE_LO+:GTM_PRE_W]),
      .load(ld),
      .match(match_r[i][H-1:0]),
      .tick_in(tick),
      .pin_edge(pin_edge[i]),
      .count_r(cnt[i]),
      .capt_r(capt[i]),
      .timeout(tmo[i]),
      .pwm_r(pwm_raw[i]),
      .done_r(done[i])
    );
  end

  always_comb begin
    tmo_sticky_nxt = tmo_sticky_r;
    adc_trigger_nxt = 1'b0;
    for (int k = 0; k < 2*NBLK; k++) begin
      ccp_oe_nxt[k] = (ctl_r[k][GTM_CTL_MODE_LO+:3] == GTM_M_PWM) &&
                      (cfg_r[k/2] != GTM_CFG_JOIN);
      ccp_out_nxt[k] = pwm_raw[k] ^ ctl_r[k][GTM_CTL_INV];
      if (tmo[k] && ctl_r[k][GTM_CTL_TRIG]) begin
        adc_trigger_nxt = 1'b1;
      end
    end
    // status write-one-to-clear; a new time-out in the same cycle wins
    if (wr_acc) begin
      for (int b = 0; b < NBLK; b++) begin
        if (paddr == 12'(b) * GTM_BLK_STRIDE + 12'(GTM_OFS_STAT)) begin
          tmo_sticky_nxt[2*b+:2] = tmo_sticky_r[2*b+:2] & ~pwdata[1:0];
        end
      end
    end
    tmo_sticky_nxt = tmo_sticky_nxt | tmo;
  end

  always_comb begin
    logic [4:0] ofs;
    logic hit;
    ofs = paddr[4:0];
    hit = 1'b0;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    for (int b = 0; b < NBLK; b++) begin
      cfg_nxt[b] = cfg_r[b];
      ctl_nxt[2*b] = ctl_r[2*b];
      ctl_nxt[2*b+1] = ctl_r[2*b+1];
      load_nxt[2*b] = load_r[2*b];
      load_nxt[2*b+1] = load_r[2*b+1];
      match_nxt[2*b] = match_r[2*b];
      match_nxt[2*b+1] = match_r[2*b+1];
      if (paddr[11:5] == 7'(b) && psel) begin
        hit = 1'b1;
        if (ofs == GTM_OFS_CFG) begin
          if (wr_acc) cfg_nxt[b] = pwdata[1:0];
          prdata_nxt = {30'h0, cfg_r[b]};
        end else if (ofs == GTM_OFS_CTL_A) begin
          if (wr_acc) ctl_nxt[2*b] = pwdata;
          prdata_nxt = ctl_r[2*b];
        end else if (ofs == GTM_OFS_CTL_B) begin
          if (wr_acc) ctl_nxt[2*b+1] = pwdata;
          prdata_nxt = ctl_r[2*b+1];
        end else if (ofs == GTM_OFS_LOAD_A) begin
          if (wr_acc) load_nxt[2*b] = pwdata;
          prdata_nxt = load_r[2*b];
        end else if (ofs == GTM_OFS_LOAD_B) begin
          if (wr_acc) load_nxt[2*b+1] = pwdata;
          prdata_nxt = load_r[2*b+1];
        end else if (ofs == GTM_OFS_MATCH_A) begin
          if (wr_acc) match_nxt[2*b] = pwdata;
          prdata_nxt = match_r[2*b];
        end else if (ofs == GTM_OFS_MATCH_B) begin
          if (wr_acc) match_nxt[2*b+1] = pwdata;
          prdata_nxt = match_r[2*b+1];
        end else begin
          // status: sticky time-outs, done flags, pin levels, live counts, half A capture
          prdata_nxt = {capt[2*b][7:0], cnt[2*b+1][7:0], cnt[2*b][7:0],
                        2'b00, pin_d2_r[2*b+:2], done[2*b+:2], tmo_sticky_r[2*b+:2]};
        end
      end
    end
    // answer registered in the setup cycle, so it stands at the access edge
    if (psel && !penable && !hit) pslverr_nxt = 1'b1;
    if (!rd_setup) prdata_nxt = 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < NBLK; b++) cfg_r[b] <= GTM_CFG_SPLIT;
      for (int k = 0; k < 2*NBLK; k++) begin
        ctl_r[k] <= GTM_CTL_RST;
        load_r[k] <= GTM_LOAD_RST;
        match_r[k] <= GTM_MATCH_RST;
      end
      tmo_sticky_r <= '0;
      ccp_pin_out <= '0;
      ccp_pin_oe <= '0;
      adc_trigger <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      ctl_r <= ctl_nxt;
      load_r <= load_nxt;
      match_r <= match_nxt;
      tmo_sticky_r <= tmo_sticky_nxt;
      ccp_pin_out <= ccp_out_nxt;
      ccp_pin_oe <= ccp_oe_nxt;
      adc_trigger <= adc_trigger_nxt;
      prdata <= prdata_nxt;
      pready <= 1'b1;
      pslverr <= pslverr_nxt;
    end
  end
endmodule : gtm_timer

/* File: hdl/gtm_pkg.sv */
// package for the general timer module: register map, fields, modes
package gtm_pkg;
  localparam int GTM_NUM_BLOCKS = 3;
  localparam int GTM_HALF_W = 16;
  localparam int GTM_PRE_W = 8;
  // per block register window: 8 words, 32 bytes
  localparam logic [11:0] GTM_BLK_STRIDE = 12'h020;
  localparam logic [4:0] GTM_OFS_CFG = 5'h00;
  localparam logic [4:0] GTM_OFS_CTL_A = 5'h04;
  localparam logic [4:0] GTM_OFS_CTL_B = 5'h08;
  localparam logic [4:0] GTM_OFS_LOAD_A = 5'h0C;
  localparam logic [4:0] GTM_OFS_LOAD_B = 5'h10;
  localparam logic [4:0] GTM_OFS_MATCH_A = 5'h14;
  localparam logic [4:0] GTM_OFS_MATCH_B = 5'h18;
  localparam logic [4:0] GTM_OFS_STAT = 5'h1C;
  // control field positions
  localparam int GTM_CTL_EN = 0;
  localparam int GTM_CTL_MODE_LO = 1;
  localparam int GTM_CTL_EVT = 4;
  localparam int GTM_CTL_INV = 5;
  localparam int GTM_CTL_TRIG = 6;
  localparam int GTM_CTL_PRE_LO = 8;
  localparam logic [31:0] GTM_CTL_RST = 32'h0000_0000;
  localparam logic [31:0] GTM_LOAD_RST = 32'h0000_FFFF;
  localparam logic [31:0] GTM_MATCH_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    GTM_M_ONESHOT = 3'b000,
    GTM_M_PERIODIC = 3'b001,
    GTM_M_CAPTURE = 3'b010,
    GTM_M_PWM = 3'b011,
    GTM_M_RTC = 3'b100
  } gtm_mode_e;
  // cfg values
  localparam logic [1:0] GTM_CFG_SPLIT = 2'h0;
  localparam logic [1:0] GTM_CFG_JOIN = 2'h1;
endpackage : gtm_pkg

/* File: hdl/gtm_counter.sv */
// one down-counting timer half with prescaler, capture and pwm
`timescale 1ns/1ns
module gtm_counter
  import gtm_pkg::*;
#(
  parameter int W = 16,
  parameter int PW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [2:0] mode,
  input wire logic evt_mode,
  input wire logic [PW-1:0] pre_load,
  input wire logic [W-1:0] load,
  input wire logic [W-1:0] match,
  input wire logic tick_in,
  input wire logic pin_edge,
  output logic [W-1:0] count_r,
  output logic [W-1:0] capt_r,
  output logic timeout,
  output logic pwm_r,
  output logic done_r
);
  logic [W-1:0] count_nxt;
  logic [W-1:0] capt_nxt;
  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  logic pwm_nxt;
  logic done_nxt;
  logic step;

  initial begin
    if (W < 2 || PW < 1) $error("gtm_counter: bad widths");
  end

  always_comb begin
    count_nxt = count_r;
    capt_nxt = capt_r;
    pre_nxt = pre_r;
    pwm_nxt = pwm_r;
    done_nxt = done_r;
    step = 1'b0;
    timeout = 1'b0;
    if (!enable) begin
      count_nxt = load;
      pre_nxt = pre_load;
      done_nxt = 1'b0;
      pwm_nxt = 1'b0;
    end else if (!done_r) begin
      // event counting: step on pin edges, else on the incoming tick
      if (evt_mode) begin
        step = pin_edge;
      end else if (pre_r != '0) begin
        pre_nxt = pre_r - 1'b1;
      end else begin
        pre_nxt = pre_load;
        step = tick_in;
      end
      if (mode == GTM_M_CAPTURE && pin_edge) begin
        capt_nxt = count_r;
      end
      if (step) begin
        if (count_r == '0) begin
          timeout = 1'b1;
          count_nxt = load;
          if (mode == GTM_M_ONESHOT) begin
            done_nxt = 1'b1;
            count_nxt = '0;
          end
        end else begin
          count_nxt = count_r - 1'b1;
        end
      end
      if (mode == GTM_M_PWM) begin
        pwm_nxt = (count_r < match);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
      capt_r <= '0;
      pre_r <= '0;
      pwm_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      capt_r <= capt_nxt;
      pre_r <= pre_nxt;
      pwm_r <= pwm_nxt;
      done_r <= done_nxt;
    end
  end
endmodule : gtm_counter

/* File: sim/gtm_timer_props.sv */
// checker: apb answers, pin enables and trigger pulses of the timer
`timescale 1ns/1ns
module gtm_timer_props #(
  parameter int NBLK = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2*NBLK-1:0] ccp_pin_oe,
  input wire logic adc_trigger
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable;
  a_ready_up: assert property ($past(presetn) |-> pready)
    else $error("pready low outside reset");
  a_err_unmapped: assert property ((acc && paddr[11:5] >= 7'(NBLK)) |-> pslverr)
    else $error("no error for unmapped block");
  a_err_mapped: assert property ((acc && paddr[11:5] < 7'(NBLK)) |-> !pslverr)
    else $error("error for mapped block");
  a_err_cause: assert property (pslverr |-> acc)
    else $error("error without access");
  a_err_one: assert property (pslverr |=> !pslverr)
    else $error("error stands too long");
  a_rdata_idle: assert property (!(psel && !penable && !pwrite) |=> prdata == 32'h0)
    else $error("read data outside read answer");
  a_trig_pulse: assert property (adc_trigger |=> !adc_trigger)
    else $error("trigger longer than one cycle");
  a_oe_cause: assert property ($changed(ccp_pin_oe) |->
    ($past(acc && pwrite) || $past(acc && pwrite, 2)))
    else $error("pin enable moved without a write");
endmodule : gtm_timer_props
bind gtm_timer gtm_timer_props #(.NBLK(NBLK)) gtm_timer_props_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ccp_pin_oe(ccp_pin_oe),
  .adc_trigger(adc_trigger));

/* File: sim/gtm_pin_src.sv */
// external event source: bursts of pulses on selected timer pins
`timescale 1ns/1ns
module gtm_pin_src (
  input wire logic pclk,
  input wire logic start,
  input wire logic [3:0] n_pulse,
  input wire logic [5:0] sel,
  output logic [5:0] pin
);
  logic [5:0] cnt_r = 6'h00;
  always_ff @(posedge pclk) begin
    if (start) cnt_r <= {n_pulse, 2'h0};
    else if (cnt_r != 6'h00) cnt_r <= cnt_r - 6'h01;
  end
  // two cycles high, two low, so the two-flop sync sees every edge
  assign pin = sel & {6{cnt_r[1]}};
endmodule : gtm_pin_src

/* File: sim/gtm_timer_tb_top.sv */
// testbench: register rows, timer modes, pins and trigger
`timescale 1ns/1ns
module gtm_timer_tb_top;
  import gtm_pkg::*;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e;} gtm_row_s;
  gtm_row_s rows[8] = '{'{12'h004, 1'b0, 32'h0, GTM_CTL_RST},
    '{12'h02C, 1'b0, 32'h0, GTM_LOAD_RST}, '{12'h050, 1'b0, 32'h0, GTM_LOAD_RST},
    '{12'h054, 1'b0, 32'h0, GTM_MATCH_RST}, '{12'h00C, 1'b1, 32'h0001_2345, 32'h0001_2345},
    '{12'h050, 1'b1, 32'h0000_ABCD, 32'h0000_ABCD}, '{12'h034, 1'b1, 32'h7, 32'h7},
    '{12'h02C, 1'b0, 32'h0, GTM_LOAD_RST}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, start = 0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic pready, pslverr, adc_trigger;
  logic [5:0] pin_out, pin_oe, src, pin_w, sel = 6'h0;
  int err_count = 0, samples_checked = 0, trig_cnt = 0, cyc = 0, hi = 0;
  // pins driven by the timer win over the event source
  assign pin_w = (pin_oe & pin_out) | (~pin_oe & src);
  gtm_timer gtm_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ccp_pin_in(pin_w), .ccp_pin_out(pin_out), .ccp_pin_oe(pin_oe),
    .adc_trigger(adc_trigger));
  gtm_pin_src gtm_pin_src_i (.pclk(pclk), .start(start), .n_pulse(4'h6), .sel(sel),
    .pin(src));
  initial forever #5 pclk = ~pclk;
  // pulses counted at the falling edge, clear of the bench's own clears
  always @(negedge pclk) begin
    if (adc_trigger === 1'b1) trig_cnt++;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // answer is registered in the setup cycle and taken at the access edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    v = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  initial begin
    idle(3);
    chk("reset out", {24'h0, pready, pin_oe, adc_trigger}, 32'h0);
    idle(3);
    presetn <= 1;
    foreach (rows[i]) begin
      if (rows[i].w) apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, 32'h0);
      chk("row", v, rows[i].e);
    end
    apb(12'h060, 1'b0, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    $display("register rows done");
    apb(12'h00C, 1'b1, 32'h5);
    trig_cnt = 0;
    apb(12'h004, 1'b1, 32'h41);
    idle(40);
    chk("oneshot trig", trig_cnt, 32'h1);
    apb(12'h004, 1'b1, 32'h0);
    apb(12'h004, 1'b1, 32'h43);
    trig_cnt = 0;
    idle(40);
    // load of five gives one time-out every six cycles
    chk("periodic trig", trig_cnt, 32'h6);
    apb(12'h004, 1'b1, 32'h0343);
    trig_cnt = 0;
    idle(40);
    // prescale of three stretches each tick, so fewer time-outs fit
    chk("prescaled trig", {31'h0, trig_cnt > 0 && trig_cnt < 3}, 32'h1);
    apb(12'h004, 1'b1, 32'h0);
    $display("timer modes done");
    apb(12'h010, 1'b1, 32'h2);
    apb(12'h008, 1'b1, 32'h53);
    trig_cnt = 0;
    idle(30);
    chk("no events", trig_cnt, 32'h0);
    sel <= 6'h02;
    start <= 1;
    idle(1);
    start <= 0;
    idle(40);
    // six edges on a load of two wrap the counter twice
    chk("event trig", trig_cnt, 32'h2);
    apb(12'h008, 1'b1, 32'h0);
    $display("event count done");
    apb(12'h024, 1'b1, 32'h6);
    idle(3);
    chk("pwm oe", pin_oe, 6'h04);
    chk("pwm level", pin_out[2], 1'b0);
    apb(12'h024, 1'b1, 32'h26);
    idle(3);
    chk("pwm inverted", pin_out[2], 1'b1);
    apb(12'h02C, 1'b1, 32'h9);
    apb(12'h024, 1'b1, 32'h27);
    idle(12);
    hi = 0;
    repeat (20) begin
      @(negedge pclk);
      if (pin_out[2]) hi++;
    end
    // period of ten, low while the count is under seven once inverted
    chk("pwm duty", hi, 32'h6);
    $display("pwm done");
    apb(12'h044, 1'b1, 32'h6);
    idle(3);
    chk("split oe", pin_oe[4], 1'b1);
    apb(12'h040, 1'b1, 32'h1);
    idle(3);
    chk("joined oe", pin_oe[4], 1'b0);
    apb(12'h04C, 1'b1, 32'h0001_0002);
    apb(12'h044, 1'b1, 32'h3);
    idle(20);
    apb(12'h05C, 1'b0, 32'h0);
    // once the high half steps, the low half runs on down from all ones
    chk("joined high", v[23:16], 32'h0);
    chk("joined low", {31'h0, v[15:8] > 8'h80}, 32'h1);
    $display("join done");
    presetn <= 0;
    idle(2);
    chk("mid reset", {24'h0, pready, pin_oe, adc_trigger}, 32'h0);
    presetn <= 1;
    apb(12'h044, 1'b0, 32'h0);
    chk("after reset", v, GTM_CTL_RST);
    $display("reset done");
    end_of_test();
  end
endmodule : gtm_timer_tb_top
